// ### dv/eprom_card_model.sv
// Purpose: behavioural memory card of eprom sockets
// Assumes: 32 words modelled; words past them read as programmed
// Notes: stuck holds bit 0 high so a verify can fail on purpose
`timescale 1ns/1ps
module eprom_card_model (
  input wire logic clk,
  input wire logic present,
  input wire logic stuck,
  input wire logic [16:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_oe,
  input wire logic mem_pgm,
  output logic [15:0] mem_rdata
);
  logic [15:0] cells [0:31];
  // erased card, first zero bit at byte offset 8
  initial begin
    foreach (cells[i]) cells[i] = 16'hffff;
    cells[4] = 16'h00ff;
  end
  // programming clears bits as a real cell does, and stuck forces bit 0 high
  always @(posedge clk) begin
    if (present && mem_pgm && mem_oe && mem_addr < 17'h0_0020) begin
      cells[mem_addr[4:0]] <= (cells[mem_addr[4:0]] & mem_wdata)
        | {15'h0000, stuck};
    end
  end
  always_comb begin
    if (!present) mem_rdata = 16'hffff;
    else if (mem_addr < 17'h0_0020) mem_rdata = cells[mem_addr[4:0]];
    else mem_rdata = 16'h0000;
  end
endmodule

// ### dv/eprom_programmer_regs_bench.sv
// Purpose: self-checking bench for the eprom programmer registers
// Assumes: program times shortened to 20 and 5 cycles
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
module eprom_programmer_regs_bench;
  logic clk, rst, reg_rd, reg_wr, rd_valid, wr_done, busy, err;
  logic card_present, card_large, mem_oe, mem_pgm, stuck, got_err;
  logic [2:0] reg_num;
  logic [31:0] reg_wdata, reg_rdata, card_base, rdata;
  logic [7:0] err_code;
  logic [15:0] mem_rdata, mem_wdata;
  logic [16:0] mem_addr;
  int err_count, comparisons, cycles, pgm_cnt;

  eprom_programmer_regs #(.SLOW_PGM_CYCLES(20), .FAST_PGM_CYCLES(5)) u_dut (
    .clk(clk), .rst(rst), .reg_num(reg_num), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rd_valid(rd_valid), .wr_done(wr_done), .busy(busy), .err(err),
    .err_code(err_code), .card_present(card_present),
    .card_large(card_large), .card_base(card_base),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_oe(mem_oe), .mem_pgm(mem_pgm));
  eprom_card_model u_card (.clk(clk), .present(card_present),
    .stuck(stuck), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_oe(mem_oe), .mem_pgm(mem_pgm), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cycle ceiling cuts a hang short; pulse length counted here
  always @(posedge clk) begin
    cycles++;
    if (mem_pgm === 1'b1) pgm_cnt++;
    if (cycles == 5000) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, cycles, 0);
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one request held a cycle; busy would drop it, so wait the answer out
  task automatic access(input logic wr, input logic [2:0] num,
      input logic [31:0] data);
    int n;
    n = 0;
    @(negedge clk);
    {reg_wr, reg_rd, reg_num, reg_wdata} = {wr, !wr, num, data};
    got_err = 1'b0;
    do begin
      @(negedge clk);
      {reg_wr, reg_rd} = 2'h0;
      n++;
      got_err = got_err | (err === 1'b1);
      if (rd_valid === 1'b1) rdata = reg_rdata;
    end while (!(rd_valid === 1'b1 || wr_done === 1'b1 || err === 1'b1)
      && n < 100);
    // an answer that never comes counts against the run
    if (n >= 100) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, n, 100);
    end
    repeat (2) begin
      @(negedge clk);
      got_err = got_err | (err === 1'b1);
    end
  endtask

  task automatic t_regs();
    access(0, eprom_pkg::REG_ID_RESET, 32'h0);
    chk(rdata, 32'(eprom_pkg::CARD_ID));
    access(0, eprom_pkg::REG_PGM_TIME, 32'h0);
    chk(rdata, 32'h0);
    access(1, eprom_pkg::REG_PGM_TIME, 32'h3);
    access(0, eprom_pkg::REG_PGM_TIME, 32'h0);
    chk(rdata, 32'h1);
    access(1, eprom_pkg::REG_OFFSET, 32'h10);
    access(1, eprom_pkg::REG_ID_RESET, 32'h0);
    access(0, eprom_pkg::REG_PGM_TIME, 32'h0);
    chk(rdata, 32'h1);
    access(1, eprom_pkg::REG_ID_RESET, 32'h80);
    access(0, eprom_pkg::REG_PGM_TIME, 32'h0);
    chk(rdata, 32'h0);
    access(0, eprom_pkg::REG_OFFSET, 32'h0);
    chk(rdata, 32'h0);
  endtask
  task automatic t_program();
    int c0;
    access(1, eprom_pkg::REG_OFFSET, 32'h20);
    c0 = pgm_cnt;
    access(1, eprom_pkg::REG_DATA, 32'h12ff);
    chk(32'(got_err), 32'h0);
    chk(32'(pgm_cnt - c0 inside {[20:21]}), 32'h1);
    access(1, eprom_pkg::REG_PGM_TIME, 32'h1);
    access(1, eprom_pkg::REG_OFFSET, 32'h22);
    c0 = pgm_cnt;
    access(1, eprom_pkg::REG_DATA, 32'hff34);
    chk(32'(pgm_cnt - c0 inside {[5:6]}), 32'h1);
    access(1, eprom_pkg::REG_OFFSET, 32'h20);
    access(0, eprom_pkg::REG_DATA, 32'h0);
    chk(rdata, 32'h12ff);
    access(1, eprom_pkg::REG_OFFSET, 32'h22);
    access(0, eprom_pkg::REG_DATA, 32'h0);
    chk(rdata, 32'hff34);
  endtask
  task automatic t_refuse();
    access(1, eprom_pkg::REG_OFFSET, 32'h24);
    access(1, eprom_pkg::REG_DATA, 32'h0);
    access(1, eprom_pkg::REG_DATA, 32'h0);
    chk(32'(err_code), 32'(eprom_pkg::ERR_NO_OFFSET));
    access(1, eprom_pkg::REG_OFFSET, 32'h25);
    access(1, eprom_pkg::REG_DATA, 32'h0);
    chk(32'(err_code), 32'(eprom_pkg::ERR_ODD_OFFSET));
    stuck = 1'b1;
    access(1, eprom_pkg::REG_OFFSET, 32'h26);
    access(1, eprom_pkg::REG_DATA, 32'hfff0);
    chk(32'(err_code), 32'(eprom_pkg::ERR_VERIFY));
    stuck = 1'b0;
  endtask
  task automatic t_erased();
    access(1, eprom_pkg::REG_OFFSET, 32'h0);
    access(0, eprom_pkg::REG_ERASED, 32'h0);
    chk(rdata, 32'h8);
    access(1, eprom_pkg::REG_OFFSET, 32'h8);
    access(0, eprom_pkg::REG_ERASED, 32'h0);
    chk(rdata, 32'h0);
  endtask
  // card pins pass two flops, so each change is let settle before use
  task automatic t_card();
    access(0, eprom_pkg::REG_CAPACITY, 32'h0);
    chk(rdata, eprom_pkg::CAP_LARGE);
    card_large = 1'b0;
    repeat (3) @(negedge clk);
    access(0, eprom_pkg::REG_BASE, 32'h0);
    chk(rdata, card_base);
    access(0, eprom_pkg::REG_CAPACITY, 32'h0);
    chk(rdata, eprom_pkg::CAP_SMALL);
    card_present = 1'b0;
    repeat (3) @(negedge clk);
    access(0, eprom_pkg::REG_BASE, 32'h0);
    chk(32'(err_code), 32'(eprom_pkg::ERR_NO_CARD));
    access(0, eprom_pkg::REG_CAPACITY, 32'h0);
    chk(rdata, 32'h0);
    access(0, eprom_pkg::REG_ERASED, 32'h0);
    chk(32'(got_err), 32'h1);
  endtask

  initial begin
    {rst, reg_rd, reg_wr, reg_num, reg_wdata, stuck} = {3'h4, 36'h0};
    {card_present, card_large, card_base} = {2'h3, 32'h0010_0000};
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_program();
    t_refuse();
    t_erased();
    t_card();
    summarize();
  end
endmodule

// ### dv/eprom_regs_properties.sv
// Purpose: port-level checks on the eprom programmer registers
// Assumes: card pins steady three cycles count as settled
// Notes: bound to every programmer instance
`timescale 1ns/1ps
module eprom_regs_props #(
  parameter int SLOW_PGM_CYCLES = 20,
  parameter int FAST_PGM_CYCLES = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] reg_num,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic rd_valid,
  input wire logic wr_done,
  input wire logic busy,
  input wire logic err,
  input wire logic [7:0] err_code,
  input wire logic card_present,
  input wire logic card_large,
  input wire logic mem_oe,
  input wire logic mem_pgm
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // read taken this edge; a write wins over a read
  wire logic idle_rd = reg_rd && !reg_wr && !busy;

  a_id_read: assert property (
    idle_rd && reg_num == eprom_pkg::REG_ID_RESET
    |=> rd_valid && reg_rdata == 32'(eprom_pkg::CARD_ID))
    else $error("id read wrong");
  a_word_read: assert property (
    idle_rd && reg_num == eprom_pkg::REG_DATA |-> ##6 rd_valid)
    else $error("word read late");
  a_cap_large: assert property (
    idle_rd && reg_num == eprom_pkg::REG_CAPACITY && card_present
    && card_large && $past(card_present, 3) && $past(card_large, 3)
    |=> reg_rdata == eprom_pkg::CAP_LARGE)
    else $error("capacity wrong");
  a_base_absent: assert property (
    idle_rd && reg_num == eprom_pkg::REG_BASE && !card_present
    && !$past(card_present, 3)
    |=> err && err_code == eprom_pkg::ERR_NO_CARD)
    else $error("absent base not refused");
  a_soft_reset: assert property (
    reg_wr && !busy && reg_num == eprom_pkg::REG_ID_RESET
    && reg_wdata != 32'h0 |=> wr_done && err_code == 8'h00)
    else $error("soft reset wrong");
  a_pgm_hold: assert property (
    $rose(mem_pgm) |-> (mem_pgm && mem_oe)[*5])
    else $error("program pulse short");
  a_pgm_end: assert property (
    $rose(mem_pgm) |-> ##[5:22] !mem_pgm)
    else $error("program pulse long");
  a_verify_done: assert property (
    $fell(mem_pgm) |-> ##[4:7] wr_done)
    else $error("verify not finished");
  a_reset_quiet: assert property (
    $fell(rst) |-> !busy && !mem_pgm && err_code == 8'h00)
    else $error("reset state wrong");

  c_program: cover property ($rose(mem_pgm));
  c_verify_err: cover property (err && err_code == eprom_pkg::ERR_VERIFY);
  c_odd_err: cover property (err && err_code == eprom_pkg::ERR_ODD_OFFSET);
endmodule

bind eprom_programmer_regs eprom_regs_props #(
  .SLOW_PGM_CYCLES(SLOW_PGM_CYCLES),
  .FAST_PGM_CYCLES(FAST_PGM_CYCLES)
) u_props (
  .clk(clk), .rst(rst), .reg_num(reg_num), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .rd_valid(rd_valid), .wr_done(wr_done), .busy(busy), .err(err),
  .err_code(err_code), .card_present(card_present),
  .card_large(card_large), .mem_oe(mem_oe), .mem_pgm(mem_pgm)
);

// ### src/eprom_pkg.sv
// Purpose: shared constants and types for the eprom programmer registers
// Assumes: 40 MHz clock, 16-bit memory card words, byte offsets
// Notes: register numbers are the documented status/control indexes
package eprom_pkg;
  // register numbers (status on read, control on write)
  localparam logic [2:0] REG_ID_RESET = 3'h0;
  localparam logic [2:0] REG_PGM_TIME = 3'h1;
  localparam logic [2:0] REG_OFFSET = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam logic [2:0] REG_CAPACITY = 3'h4;
  localparam logic [2:0] REG_ERASED = 3'h5;
  localparam logic [2:0] REG_BASE = 3'h6;

  // card type code, value is arbitrary
  localparam logic [7:0] CARD_ID = 8'h5a;

  // capacities of a fully loaded card in bytes
  localparam logic [31:0] CAP_LARGE = 32'h0004_0000;
  localparam logic [31:0] CAP_SMALL = 32'h0002_0000;

  // error codes
  localparam logic [7:0] ERR_NO_CARD = 8'h54;
  localparam logic [7:0] ERR_ODD_OFFSET = 8'h50;
  localparam logic [7:0] ERR_NO_OFFSET = 8'h51;
  localparam logic [7:0] ERR_VERIFY = 8'h52;

  // reset values
  localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
  localparam logic FAST_RESET = 1'b0;

  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam real SLOW_MS = 52.5;
  localparam real FAST_MS = 13.1;
  localparam int SLOW_CYCLES = int'(SLOW_MS * CLK_HZ / 1000.0);
  localparam int FAST_CYCLES = int'(FAST_MS * CLK_HZ / 1000.0);
  // cycles to wait after driving an address: covers pin synchroniser
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_PROGRAM,
    ST_VERIFY,
    ST_COUNT
  } state_type;
endpackage

// ### src/eprom_programmer_regs.sv
// Purpose: register behaviour of a programmer for a card of eprom sockets
// Assumes: host reads status and writes control registers by number;
//   memory card pins are asynchronous and pass two flip-flops
// Notes: one request at a time; requests while busy are ignored
`timescale 1ns/1ps
module eprom_programmer_regs #(
  parameter int SLOW_PGM_CYCLES = eprom_pkg::SLOW_CYCLES,
  parameter int FAST_PGM_CYCLES = eprom_pkg::FAST_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] reg_num,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic rd_valid,
  output logic wr_done,
  output logic busy,
  output logic err,
  output logic [7:0] err_code,
  input wire logic card_present,
  input wire logic card_large,
  input wire logic [31:0] card_base,
  input wire logic [15:0] mem_rdata,
  output logic [16:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic mem_oe,
  output logic mem_pgm
);
  typedef struct packed {
    eprom_pkg::state_type st;
    logic [1:0] pres_s;
    logic [1:0] large_s;
    logic [15:0] rd_s1;
    logic [15:0] rd_s2;
    logic [31:0] base_s1;
    logic [31:0] base_s2;
    logic fast;
    logic [31:0] offset;
    logic loaded;
    logic [31:0] walk;
    logic [31:0] count;
    logic [2:0] settle;
    logic [16:0] mem_addr;
    logic [15:0] mem_wdata;
    logic mem_oe;
    logic mem_pgm;
    logic [31:0] rdata;
    logic rd_valid;
    logic wr_done;
    logic err;
    logic [7:0] err_code;
    logic busy;
    logic tstart;
  } regs_type;

  regs_type r_ff;
  regs_type nxt_r;
  logic timer_done;
  logic [31:0] timer_load;
  logic present;
  logic [31:0] capacity;
  logic [15:0] card_word;
  logic [7:0] walk_byte;

  localparam logic [31:0] SLOW_LOAD = 32'(SLOW_PGM_CYCLES);
  localparam logic [31:0] FAST_LOAD = 32'(FAST_PGM_CYCLES);

  // time by select
  // registered start and done each add a cycle, so load one less;
  // the pulse then lasts the selected time plus one cycle
  assign timer_load = (r_ff.fast ? FAST_LOAD : SLOW_LOAD) - 32'h0000_0001;

  pgm_timer u_timer (
    .clk(clk),
    .rst(rst),
    .start(r_ff.tstart),
    .load(timer_load),
    .done(timer_done)
  );

  assign present = r_ff.pres_s[1];

  assign capacity = !present ? 32'h0000_0000 :
                    (r_ff.large_s[1] ? eprom_pkg::CAP_LARGE :
                     eprom_pkg::CAP_SMALL);

  assign card_word = present ? r_ff.rd_s2 : 16'hffff;

  // even byte offsets sit in the upper half of a word
  assign walk_byte = r_ff.walk[0] ? card_word[7:0] : card_word[15:8];

  // next-state logic: bus decode, sequencer and pin synchronisers
  always_comb begin
    nxt_r = r_ff;
    nxt_r.pres_s = {r_ff.pres_s[0], card_present};
    nxt_r.large_s = {r_ff.large_s[0], card_large};
    nxt_r.rd_s1 = mem_rdata;
    nxt_r.rd_s2 = r_ff.rd_s1;
    nxt_r.base_s1 = card_base;
    nxt_r.base_s2 = r_ff.base_s1;
    nxt_r.rd_valid = 1'b0;
    nxt_r.wr_done = 1'b0;
    nxt_r.err = 1'b0;
    nxt_r.tstart = 1'b0;
    nxt_r.settle = (r_ff.settle != 3'h0) ? r_ff.settle - 3'h1 : 3'h0;
    case (r_ff.st)
      eprom_pkg::ST_IDLE: begin
        nxt_r.mem_oe = 1'b0;
        nxt_r.mem_pgm = 1'b0;
        if (reg_wr) begin
          nxt_r.wr_done = 1'b1;
          case (reg_num)
            eprom_pkg::REG_ID_RESET: begin
              if (reg_wdata != 32'h0000_0000) begin
                nxt_r.fast = eprom_pkg::FAST_RESET;
                nxt_r.offset = eprom_pkg::OFFSET_RESET;
                nxt_r.loaded = 1'b0;
                nxt_r.err_code = 8'h00;
              end
            end
            eprom_pkg::REG_PGM_TIME: begin
              nxt_r.fast = (reg_wdata != 32'h0000_0000);
            end
            eprom_pkg::REG_OFFSET: begin
              nxt_r.offset = reg_wdata;
              nxt_r.loaded = 1'b1;
            end
            eprom_pkg::REG_DATA: begin
              if (r_ff.offset[0]) begin
                nxt_r.err = 1'b1;
                nxt_r.err_code = eprom_pkg::ERR_ODD_OFFSET;
              end else if (!r_ff.loaded) begin
                nxt_r.err = 1'b1;
                nxt_r.err_code = eprom_pkg::ERR_NO_OFFSET;
              end else begin
                nxt_r.wr_done = 1'b0;
                nxt_r.loaded = 1'b0;
                nxt_r.mem_addr = r_ff.offset[17:1];
                nxt_r.mem_wdata = reg_wdata[15:0];
                nxt_r.mem_oe = 1'b1;
                nxt_r.mem_pgm = 1'b1;
                nxt_r.tstart = 1'b1;
                nxt_r.busy = 1'b1;
                nxt_r.st = eprom_pkg::ST_PROGRAM;
              end
            end
            default: begin
              // unused control numbers take no action
            end
          endcase
        end else if (reg_rd) begin
          nxt_r.rd_valid = 1'b1;
          case (reg_num)
            eprom_pkg::REG_ID_RESET: begin
              nxt_r.rdata = {24'h00_0000, eprom_pkg::CARD_ID};
            end
            eprom_pkg::REG_PGM_TIME: begin
              nxt_r.rdata = {31'h0000_0000, r_ff.fast};
            end
            eprom_pkg::REG_OFFSET: begin
              nxt_r.rdata = r_ff.offset;
            end
            eprom_pkg::REG_DATA: begin
              nxt_r.rd_valid = 1'b0;
              nxt_r.mem_addr = r_ff.offset[17:1];
              nxt_r.settle = eprom_pkg::SETTLE_CYCLES;
              nxt_r.busy = 1'b1;
              nxt_r.st = eprom_pkg::ST_READ;
            end
            eprom_pkg::REG_CAPACITY: begin
              nxt_r.rdata = capacity;
            end
            eprom_pkg::REG_ERASED: begin
              if (!present) begin
                nxt_r.rdata = 32'h0000_0000;
                nxt_r.err = 1'b1;
                nxt_r.err_code = eprom_pkg::ERR_NO_CARD;
              end else begin
                nxt_r.rd_valid = 1'b0;
                nxt_r.walk = r_ff.offset;
                nxt_r.count = 32'h0000_0000;
                nxt_r.mem_addr = r_ff.offset[17:1];
                nxt_r.settle = eprom_pkg::SETTLE_CYCLES;
                nxt_r.busy = 1'b1;
                nxt_r.st = eprom_pkg::ST_COUNT;
              end
            end
            eprom_pkg::REG_BASE: begin
              nxt_r.rdata = present ? r_ff.base_s2 : 32'h0000_0000;
              if (!present) begin
                nxt_r.err = 1'b1;
                nxt_r.err_code = eprom_pkg::ERR_NO_CARD;
              end
            end
            default: begin
              nxt_r.rdata = 32'h0000_0000;
            end
          endcase
        end
      end
      eprom_pkg::ST_READ: begin
        if (r_ff.settle == 3'h0) begin
          nxt_r.rdata = {16'h0000, card_word};
          nxt_r.rd_valid = 1'b1;
          nxt_r.busy = 1'b0;
          nxt_r.st = eprom_pkg::ST_IDLE;
        end
      end
      eprom_pkg::ST_PROGRAM: begin
        // pulse held until the selected time elapses
        if (timer_done) begin
          nxt_r.mem_pgm = 1'b0;
          nxt_r.mem_oe = 1'b0;
          nxt_r.settle = eprom_pkg::SETTLE_CYCLES;
          nxt_r.st = eprom_pkg::ST_VERIFY;
        end
      end
      eprom_pkg::ST_VERIFY: begin
        if (r_ff.settle == 3'h0) begin
          nxt_r.wr_done = 1'b1;
          nxt_r.busy = 1'b0;
          nxt_r.st = eprom_pkg::ST_IDLE;
          if (card_word != r_ff.mem_wdata) begin
            nxt_r.err = 1'b1;
            nxt_r.err_code = eprom_pkg::ERR_VERIFY;
          end
        end
      end
      eprom_pkg::ST_COUNT: begin
        // one byte per settle period; slow but needs no buffer
        if (r_ff.settle == 3'h0) begin
          // stop at zero bit or end
          // first byte not FF gives zero
          if (walk_byte != 8'hff || r_ff.walk >= capacity) begin
            nxt_r.rdata = r_ff.count;
            nxt_r.rd_valid = 1'b1;
            nxt_r.busy = 1'b0;
            nxt_r.st = eprom_pkg::ST_IDLE;
          end else begin
            nxt_r.count = r_ff.count + 32'h0000_0001;
            nxt_r.walk = r_ff.walk + 32'h0000_0001;
            if (r_ff.walk + 32'h0000_0001 >= capacity) begin
              nxt_r.rdata = r_ff.count + 32'h0000_0001;
              nxt_r.rd_valid = 1'b1;
              nxt_r.busy = 1'b0;
              nxt_r.st = eprom_pkg::ST_IDLE;
            end else begin
              nxt_r.mem_addr = nxt_r.walk[17:1];
              nxt_r.settle = eprom_pkg::SETTLE_CYCLES;
            end
          end
        end
      end
      default: begin
        nxt_r.st = eprom_pkg::ST_IDLE;
      end
    endcase
  end

  // all state registered here
  always_ff @(posedge clk) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign reg_rdata = r_ff.rdata;
  assign rd_valid = r_ff.rd_valid;
  assign wr_done = r_ff.wr_done;
  assign busy = r_ff.busy;
  assign err = r_ff.err;
  assign err_code = r_ff.err_code;
  assign mem_addr = r_ff.mem_addr;
  assign mem_wdata = r_ff.mem_wdata;
  assign mem_oe = r_ff.mem_oe;
  assign mem_pgm = r_ff.mem_pgm;
endmodule

// ### src/pgm_timer.sv
// Purpose: one-shot counter timing the programming pulse
// Assumes: load is at least one
// Notes: done is a one-cycle pulse when the count runs out
`timescale 1ns/1ps
module pgm_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [31:0] load,
  output logic done
);
  typedef struct packed {
    logic run;
    logic [31:0] cnt;
    logic done;
  } timer_type;

  timer_type r_ff;
  timer_type nxt_r;

  // restart wins over a running count
  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    if (start) begin
      nxt_r.run = 1'b1;
      nxt_r.cnt = load;
    end else if (r_ff.run) begin
      if (r_ff.cnt <= 32'h0000_0001) begin
        nxt_r.run = 1'b0;
        nxt_r.done = 1'b1;
      end else begin
        nxt_r.cnt = r_ff.cnt - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign done = r_ff.done;
endmodule
